// file: include/serial_port_pkg.sv
// constants, types and helpers shared by the serial port design files
package serial_port_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // clock and bit timing
  localparam int          CLOCK_HZ      = 100_000_000;
  localparam int          DEFAULT_BAUD  = 9600;
  localparam logic [15:0] DIV_DEFAULT   = 16'(CLOCK_HZ / DEFAULT_BAUD);
  localparam logic [15:0] DIV_MIN       = 16'h0010;
  localparam logic [2:0]  LAST_DATA_BIT = 3'h7;

  ////////////////////////////////////////////////////////////////////////////////
  // register byte offsets and fields
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_BAUD     = 8'h04;
  localparam logic [7:0]  ADDR_STATUS   = 8'h08;
  localparam logic [7:0]  ADDR_TXDATA   = 8'h0c;
  localparam logic [7:0]  ADDR_RXLAST   = 8'h10;
  localparam int          CTRL_ECHO_BIT = 0;
  localparam logic        ECHO_DEFAULT  = 1'b0;
  localparam int          ST_RTS        = 0;
  localparam int          ST_TX_BUSY    = 1;
  localparam int          ST_REPLY      = 2;
  localparam int          ST_SOFT_PEND  = 3;
  localparam int          ST_FRAME_ERR  = 4;
  localparam int          ST_OVERRUN    = 5;
  localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // characters, command lines and reply text
  localparam logic [7:0]   CHAR_LF    = 8'h0a;
  localparam logic [7:0]   CHAR_CR    = 8'h0d;
  localparam logic [39:0]  CMD_IDN    = "*IDN?";
  localparam logic [39:0]  CMD_RST    = {8'h00, "*RST"};
  localparam logic [2:0]   IDN_LEN    = 3'h5;
  localparam logic [2:0]   RST_LEN    = 3'h4;
  localparam logic [2:0]   MATCH_FAIL = 3'h7;
  // reply text values are arbitrary
  localparam logic [231:0] REPLY_TEXT = "NONAME,MODEL1,SN000000,FW0.0\n";
  localparam logic [4:0]   REPLY_LAST = 5'h1c;

  ////////////////////////////////////////////////////////////////////////////////
  // state types
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;
  typedef enum logic [1:0] {REPLY_IDLE, REPLY_WAIT, REPLY_SEND} reply_state_type;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [15:0] bit_reload(input logic [15:0] div);
    return 16'(div - 16'h0001);
  endfunction : bit_reload

  function automatic logic [2:0] match_step(input logic [39:0] text, input logic [2:0] len,
                                            input logic [2:0] pos, input logic [7:0] c);
    logic [2:0] idx;
    logic [5:0] base;
    idx  = 3'(len - pos - 3'h1);
    base = {idx, 3'b000};
    if (pos >= len) return MATCH_FAIL;
    else if (text[base +: 8] == c) return 3'(pos + 3'h1);
    else return MATCH_FAIL;
  endfunction : match_step

endpackage : serial_port_pkg

// file: include/serial_link_if.sv
// signals between the port core, its bit engine and its reply memory
`timescale 1ns/10ps
interface serial_link_if;
  logic [15:0] divisor;
  logic        tx_start;
  logic [7:0]  tx_byte;
  logic        tx_busy;
  logic        rx_valid;
  logic [7:0]  rx_byte;
  logic        rx_error;
  logic [4:0]  rom_addr;
  logic [7:0]  rom_data;

  modport core   (output divisor, tx_start, tx_byte, rom_addr,
                  input  tx_busy, rx_valid, rx_byte, rx_error, rom_data);
  modport engine (input  divisor, tx_start, tx_byte,
                  output tx_busy, rx_valid, rx_byte, rx_error);
  modport rom    (input  rom_addr, output rom_data);
endinterface : serial_link_if

// file: design/reply_rom.sv
// identification reply text memory with registered read data
`timescale 1ns/10ps
module reply_rom
  import serial_port_pkg::*;
(
  // clock
  input wire logic   clock,
  // read port
  serial_link_if.rom link
);

  logic [4:0] idx;
  logic [7:0] base;

  always_comb begin
    idx  = 5'(REPLY_LAST - link.rom_addr);
    base = {idx, 3'b000};
  end

  always_ff @(posedge clock) begin
    link.rom_data <= REPLY_TEXT[base +: 8];
  end

endmodule : reply_rom

// file: design/serial_bit_engine.sv
// character framing: transmit serialiser and receive sampler
`timescale 1ns/10ps
module serial_bit_engine
  import serial_port_pkg::*;
(
  // clock and reset
  input  wire logic     clock,
  input  wire logic     rst,
  // serial line
  input  wire logic     rxd,
  output logic          txd,
  // core side
  serial_link_if.engine link
);

  tx_state_type tx_state;
  logic [15:0]  tx_count;
  logic [2:0]   tx_bit;
  logic [7:0]   tx_shift;
  rx_state_type rx_state;
  logic [15:0]  rx_count;
  logic [2:0]   rx_bit;
  logic [7:0]   rx_shift;

  assign link.tx_busy = (tx_state != TX_IDLE);

  ////////////////////////////////////////////////////////////////////////////////
  // transmit: start, eight data bits lsb first, one stop bit
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_state <= TX_IDLE;
      txd      <= 1'b1;
      tx_count <= 16'h0000;
      tx_bit   <= 3'h0;
      tx_shift <= 8'h00;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          txd <= 1'b1;
          if (link.tx_start) begin
            tx_shift <= link.tx_byte;
            txd      <= 1'b0;
            tx_count <= bit_reload(link.divisor);
            tx_state <= TX_START;
          end
        end
        TX_START: begin
          if (tx_count == 16'h0000) begin
            txd      <= tx_shift[0];
            tx_bit   <= 3'h0;
            tx_count <= bit_reload(link.divisor);
            tx_state <= TX_DATA;
          end else tx_count <= 16'(tx_count - 16'h0001);
        end
        TX_DATA: begin
          if (tx_count == 16'h0000) begin
            tx_count <= bit_reload(link.divisor);
            if (tx_bit == LAST_DATA_BIT) begin
              txd      <= 1'b1;
              tx_state <= TX_STOP;
            end else begin
              tx_shift <= {1'b0, tx_shift[7:1]};
              txd      <= tx_shift[1];
              tx_bit   <= 3'(tx_bit + 3'h1);
            end
          end else tx_count <= 16'(tx_count - 16'h0001);
        end
        TX_STOP: begin
          if (tx_count == 16'h0000) tx_state <= TX_IDLE;
          else tx_count <= 16'(tx_count - 16'h0001);
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive: mid-bit sampling, stop bit checked, no parity slot
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_state      <= RX_IDLE;
      rx_count      <= 16'h0000;
      rx_bit        <= 3'h0;
      rx_shift      <= 8'h00;
      link.rx_valid <= 1'b0;
      link.rx_error <= 1'b0;
      link.rx_byte  <= 8'h00;
    end else begin
      link.rx_valid <= 1'b0;
      link.rx_error <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          if (!rxd) begin
            rx_count <= {1'b0, link.divisor[15:1]};
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (rx_count == 16'h0000) begin
            rx_count <= bit_reload(link.divisor);
            rx_bit   <= 3'h0;
            rx_state <= rxd ? RX_IDLE : RX_DATA;
          end else rx_count <= 16'(rx_count - 16'h0001);
        end
        RX_DATA: begin
          if (rx_count == 16'h0000) begin
            rx_shift <= {rxd, rx_shift[7:1]};
            rx_count <= bit_reload(link.divisor);
            if (rx_bit == LAST_DATA_BIT) rx_state <= RX_STOP;
            else rx_bit <= 3'(rx_bit + 3'h1);
          end else rx_count <= 16'(rx_count - 16'h0001);
        end
        RX_STOP: begin
          if (rx_count == 16'h0000) begin
            link.rx_valid <= rxd;
            link.rx_error <= !rxd;
            link.rx_byte  <= rx_shift;
            rx_state      <= RX_IDLE;
          end else rx_count <= 16'(rx_count - 16'h0001);
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

endmodule : serial_bit_engine

// file: design/instrument_serial_port.sv
// serial command port: bus registers, command parser, reply, echo and flow control
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module instrument_serial_port
  import serial_port_pkg::*;
(
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // serial line
  input  wire logic        RXD,
  output logic             TXD,
  output logic             RTS
);

  serial_link_if link ();

  logic            take;
  logic            wr_pending;
  logic            rd_pending;
  logic [7:0]      addr_q;
  logic [31:0]     read_word;
  logic            wr_ctrl;
  logic            wr_baud;
  logic            wr_status;
  logic            wr_txdata;
  logic            echo_on;
  logic [15:0]     divisor;
  logic            frame_err;
  logic            overrun;
  logic            overrun_event;
  logic [7:0]      rx_last;
  logic [2:0]      idn_pos;
  logic [2:0]      rst_pos;
  logic            start_reply;
  logic            cmd_reset;
  reply_state_type reply_state;
  logic [4:0]      reply_addr;
  logic            echo_pending;
  logic [7:0]      echo_byte;
  logic            soft_pending;
  logic [7:0]      soft_byte;
  logic            tx_start;
  logic [7:0]      tx_byte;
  logic            can_issue;
  logic            grant_echo;
  logic            grant_reply;
  logic            grant_soft;

  ////////////////////////////////////////////////////////////////////////////////
  // submodules

  serial_bit_engine u_engine (
    .clock (CLOCK),
    .rst   (RST),
    .rxd   (RXD),
    .txd   (TXD),
    .link  (link)
  );

  reply_rom u_rom (
    .clock (CLOCK),
    .link  (link)
  );

  assign link.divisor  = divisor;
  assign link.tx_start = tx_start;
  assign link.tx_byte  = tx_byte;
  assign link.rom_addr = reply_addr;

  ////////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: writes without wait, reads with one wait state

  assign take = HSEL & HTRANS[1] & HREADY;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wr_pending <= 1'b0;
      rd_pending <= 1'b0;
      addr_q     <= 8'h00;
      HREADYOUT  <= 1'b1;
      HRDATA     <= WORD_ZERO;
      HRESP      <= 1'b0;
    end else begin
      HRESP      <= 1'b0;
      wr_pending <= take & HWRITE;
      rd_pending <= take & !HWRITE;
      if (take) addr_q <= HADDR[7:0];
      HREADYOUT <= !(take & !HWRITE);
      if (rd_pending) HRDATA <= read_word;
    end
  end

  assign wr_ctrl   = wr_pending & (addr_q == ADDR_CTRL);
  assign wr_baud   = wr_pending & (addr_q == ADDR_BAUD);
  assign wr_status = wr_pending & (addr_q == ADDR_STATUS);
  assign wr_txdata = wr_pending & (addr_q == ADDR_TXDATA);

  always_comb begin
    read_word = WORD_ZERO;
    case (addr_q)
      ADDR_CTRL:   read_word[CTRL_ECHO_BIT] = echo_on;
      ADDR_BAUD:   read_word[15:0] = divisor;
      ADDR_STATUS: begin
        read_word[ST_RTS]       = RTS;
        read_word[ST_TX_BUSY]   = link.tx_busy;
        read_word[ST_REPLY]     = (reply_state != REPLY_IDLE);
        read_word[ST_SOFT_PEND] = soft_pending;
        read_word[ST_FRAME_ERR] = frame_err;
        read_word[ST_OVERRUN]   = overrun;
      end
      ADDR_TXDATA: read_word[7:0] = soft_byte;
      ADDR_RXLAST: read_word[7:0] = rx_last;
      default:     read_word = WORD_ZERO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // settings: echo and bit divisor, restored by reset or reset command

  always_ff @(posedge CLOCK) begin
    if (RST || cmd_reset) begin
      echo_on <= ECHO_DEFAULT;
      divisor <= DIV_DEFAULT;
    end else begin
      if (wr_ctrl) echo_on <= HWDATA[CTRL_ECHO_BIT];
      if (wr_baud) begin
        divisor <= (HWDATA[15:0] < DIV_MIN) ? DIV_MIN : HWDATA[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sticky status flags: a new event wins over a clear in the same cycle

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      frame_err <= 1'b0;
    end else begin
      frame_err <= link.rx_error | (frame_err & !(wr_status & HWDATA[ST_FRAME_ERR]));
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      overrun <= 1'b0;
    end else begin
      overrun <= overrun_event | (overrun & !(wr_status & HWDATA[ST_OVERRUN]));
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) rx_last <= 8'h00;
    else if (link.rx_valid) rx_last <= link.rx_byte;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // command parser: lines end at line feed, carriage return skipped

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      idn_pos     <= 3'h0;
      rst_pos     <= 3'h0;
      start_reply <= 1'b0;
      cmd_reset   <= 1'b0;
    end else begin
      start_reply <= 1'b0;
      cmd_reset   <= 1'b0;
      if (link.rx_valid) begin
        if (link.rx_byte == CHAR_LF) begin
          start_reply <= (idn_pos == IDN_LEN);
          cmd_reset   <= (rst_pos == RST_LEN);
          idn_pos     <= 3'h0;
          rst_pos     <= 3'h0;
        end else if (link.rx_byte != CHAR_CR) begin
          // flow-control characters take this path like any other text
          idn_pos <= match_step(CMD_IDN, IDN_LEN, idn_pos, link.rx_byte);
          rst_pos <= match_step(CMD_RST, RST_LEN, rst_pos, link.rx_byte);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // identification reply streamed from the reply memory

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      reply_state <= REPLY_IDLE;
      reply_addr  <= 5'h00;
    end else begin
      case (reply_state)
        REPLY_IDLE: begin
          if (start_reply) begin
            reply_addr  <= 5'h00;
            reply_state <= REPLY_WAIT;
          end
        end
        REPLY_WAIT: reply_state <= REPLY_SEND;
        REPLY_SEND: begin
          if (grant_reply) begin
            if (reply_addr == REPLY_LAST) begin
              reply_state <= REPLY_IDLE;
            end else begin
              reply_addr  <= 5'(reply_addr + 5'h01);
              reply_state <= REPLY_WAIT;
            end
          end
        end
        default: reply_state <= REPLY_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // echo holding byte and software transmit byte

  assign overrun_event = link.rx_valid & echo_on & echo_pending & !grant_echo;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      echo_pending <= 1'b0;
      echo_byte    <= 8'h00;
    end else begin
      if (link.rx_valid && echo_on) begin
        echo_pending <= 1'b1;
        echo_byte    <= link.rx_byte;
      end else if (grant_echo) begin
        echo_pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      soft_pending <= 1'b0;
      soft_byte    <= 8'h00;
    end else begin
      if (wr_txdata && !soft_pending) begin
        soft_pending <= 1'b1;
        soft_byte    <= HWDATA[7:0];
      end else if (grant_soft) begin
        soft_pending <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transmit arbitration: echo, then reply, then software; no cts gating

  assign can_issue   = !link.tx_busy & !tx_start;
  assign grant_echo  = can_issue & echo_pending;
  assign grant_reply = can_issue & !echo_pending & (reply_state == REPLY_SEND);
  assign grant_soft  = can_issue & !echo_pending & (reply_state != REPLY_SEND)
                       & soft_pending;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      tx_start <= 1'b0;
      tx_byte  <= 8'h00;
    end else begin
      tx_start <= grant_echo | grant_reply | grant_soft;
      if (grant_echo) tx_byte <= echo_byte;
      else if (grant_reply) tx_byte <= link.rom_data;
      else if (grant_soft) tx_byte <= soft_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // flow control: rts high while another character can be taken

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      RTS <= 1'b0;
    end else begin
      // the host is relied on to pause while this is low
      RTS <= (reply_state == REPLY_IDLE) & !start_reply & !echo_pending;
    end
  end

endmodule : instrument_serial_port

// file: dv/host_serial_model.sv
// host serial port model: honours rts, sends lf-ended lines, collects replies
`timescale 1ns/10ps
module host_serial_model
  import serial_port_pkg::*;
(
  // clock
  input  wire logic clock,
  // serial lines
  output logic      line_out,
  input  wire logic line_in,
  input  wire logic rts
);
  int         div = 10416;
  int         j;
  logic [7:0] got[$];
  logic [7:0] shift;
  logic [9:0] frame;

  initial line_out = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // transmit one frame, stop level selectable
  task send_byte(input logic [7:0] b, input logic stop_val);
    while (rts !== 1'b1) @(posedge clock);
    frame = {stop_val, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clock);
      line_out <= frame[i];
      repeat (div - 1) @(posedge clock);
    end
    @(posedge clock);
    line_out <= 1'b1;
  endtask : send_byte

  task send_line(input logic [39:0] txt, input int n);
    for (int i = 0; i < n; i++) send_byte(txt[8*(n-1-i) +: 8], 1'b1);
    send_byte(CHAR_LF, 1'b1);
  endtask : send_line

  ////////////////////////////////////////////////////////////////////////////////
  // receive: centre sampling, lsb first
  always begin
    @(negedge line_in);
    repeat (div / 2) @(posedge clock);
    for (j = 0; j < 8; j++) begin
      repeat (div) @(posedge clock);
      shift[j] = line_in;
    end
    repeat (div) @(posedge clock);
    got.push_back(shift);
  end
endmodule : host_serial_model

// file: dv/instrument_serial_port_properties.sv
// property checker for the serial command port
`timescale 1ns/10ps
module instrument_serial_port_properties
  import serial_port_pkg::*;
(
  // clock and reset
  input wire logic        CLOCK,
  input wire logic        RST,
  // bus
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [2:0]  HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  // serial
  input wire logic        RXD,
  input wire logic        TXD,
  input wire logic        RTS
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence rd_addr;
    HSEL && HTRANS[1] && HREADY && !HWRITE;
  endsequence
  sequence rd_answer;
    !HREADYOUT ##1 HREADYOUT;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  // bus
  AST_RD_WAIT: assert property (rd_addr |=> rd_answer)
    else $error("read data phase not one wait cycle");
  AST_WR_NOWAIT: assert property (HSEL && HTRANS[1] && HREADY && HWRITE |=> HREADYOUT)
    else $error("write data phase stalled");
  AST_WAIT_CAUSE: assert property ($fell(HREADYOUT) |-> $past(HSEL && HTRANS[1] && !HWRITE))
    else $error("wait state without read");
  AST_OKAY: assert property (!HRESP)
    else $error("error response");
  AST_RDATA_HOLD: assert property ($changed(HRDATA) && !$past(RST) |-> $past(!HWRITE, 2))
    else $error("read data changed outside read");

  ////////////////////////////////////////////////////////////////////////////////
  // serial line and flow control
  AST_RST_VAL: assert property ($fell(RST) |-> TXD && !RTS && HREADYOUT)
    else $error("wrong reset levels");
  AST_RTS_UP: assert property ($fell(RST) |=> RTS)
    else $error("rts not raised after reset");
  AST_LOW_MIN: assert property ($fell(TXD) |-> (!TXD)[*8])
    else $error("low bit too short");
  AST_HIGH_MIN: assert property ($rose(TXD) |-> TXD[*8])
    else $error("high bit too short");
endmodule : instrument_serial_port_properties

bind instrument_serial_port instrument_serial_port_properties chk (
  .CLOCK(CLOCK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RXD(RXD), .TXD(TXD), .RTS(RTS));

// file: dv/test_instrument_serial_port.sv
// self-checking bench for the serial command port
`timescale 1ns/10ps
module test_instrument_serial_port
  import serial_port_pkg::*;
;
  localparam int LIMIT = 60000;
  logic        clock = 1'b0;
  logic        rst   = 1'b1;
  logic        hsel  = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = WORD_ZERO;
  logic [31:0] hwdata = WORD_ZERO;
  logic [31:0] rdata;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, txd, rts, rxd;
  int          fail_count = 0;
  int          tests_run = 0;
  int          cycles = 0;

  always #5 clock = ~clock;

  instrument_serial_port uut (.CLOCK(clock), .RST(rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .RXD(rxd), .TXD(txd), .RTS(rts));
  host_serial_model host (.clock(clock), .line_out(rxd), .line_in(txd), .rts(rts));

  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask : bus

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, WORD_ZERO);
    check(rdata, exp);
  endtask : rd_chk

  task wait_rx(input int n);
    while (host.got.size() < n) @(posedge clock);
  endtask : wait_rx

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task t_defaults;
    rd_chk(ADDR_CTRL, WORD_ZERO);
    rd_chk(ADDR_BAUD, 32'(DIV_DEFAULT));
    rd_chk(ADDR_STATUS, 32'h0000_0001);
    bus(1'b1, 8'h20, 32'hffff_ffff);
    rd_chk(8'h20, WORD_ZERO);
    rd_chk(ADDR_BAUD, 32'(DIV_DEFAULT));
    rd_chk(ADDR_RXLAST, WORD_ZERO);
  endtask : t_defaults

  task t_baud;
    bus(1'b1, ADDR_BAUD, 32'h0000_0005);
    rd_chk(ADDR_BAUD, 32'(DIV_MIN));
    bus(1'b1, ADDR_BAUD, 32'h0000_06c8);
    rd_chk(ADDR_BAUD, 32'h0000_06c8);
    bus(1'b1, ADDR_BAUD, 32'h0000_0010);
    host.div = 16;
  endtask : t_baud

  task t_echo;
    logic [7:0] list[3];
    list = '{8'h13, 8'h11, 8'h5a};
    bus(1'b1, ADDR_CTRL, 32'h0000_0001);
    foreach (list[i]) begin
      host.send_byte(list[i], 1'b1);
      wait_rx(1);
      check(32'(host.got.pop_front()), 32'(list[i]));
    end
    rd_chk(ADDR_RXLAST, 32'h0000_005a);
    bus(1'b1, ADDR_CTRL, WORD_ZERO);
    host.send_byte(8'h41, 1'b1);
    repeat (400) @(posedge clock);
    check(32'(host.got.size()), WORD_ZERO);
  endtask : t_echo

  task t_idn;
    // earlier characters left an open line: close it so the query starts fresh
    host.send_byte(CHAR_LF, 1'b1);
    host.got.delete();
    host.send_line(CMD_IDN, 5);
    bus(1'b0, ADDR_STATUS, WORD_ZERO);
    check(rdata & 32'h5, 32'h4);
    wait_rx(29);
    for (int i = 0; i < 29; i++) check(32'(host.got[i]), 32'(REPLY_TEXT[8*(28-i) +: 8]));
    repeat (40) @(posedge clock);
    bus(1'b0, ADDR_STATUS, WORD_ZERO);
    check(rdata & 32'h5, 32'h1);
    host.got.delete();
  endtask : t_idn

  task t_rst;
    host.send_line(CMD_RST, 4);
    repeat (20) @(posedge clock);
    rd_chk(ADDR_BAUD, 32'(DIV_DEFAULT));
    rd_chk(ADDR_CTRL, WORD_ZERO);
    bus(1'b1, ADDR_BAUD, 32'h0000_0010);
  endtask : t_rst

  task t_tx;
    bus(1'b1, ADDR_TXDATA, 32'h0000_00a5);
    rd_chk(ADDR_TXDATA, 32'h0000_00a5);
    bus(1'b0, ADDR_STATUS, WORD_ZERO);
    check(rdata & 32'ha, 32'h2);
    wait_rx(1);
    check(32'(host.got.pop_front()), 32'h0000_00a5);
  endtask : t_tx

  task t_ferr;
    host.send_byte(8'h55, 1'b0);
    repeat (64) @(posedge clock);
    bus(1'b0, ADDR_STATUS, WORD_ZERO);
    check(rdata & 32'h10, 32'h10);
    bus(1'b1, ADDR_STATUS, 32'h0000_0010);
    bus(1'b0, ADDR_STATUS, WORD_ZERO);
    check(rdata & 32'h10, WORD_ZERO);
  endtask : t_ferr

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence and timeout
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_defaults;
    t_baud;
    t_echo;
    t_idn;
    t_rst;
    t_tx;
    t_ferr;
    end_sim;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      end_sim;
    end
  end
endmodule : test_instrument_serial_port
